// ==== rtl/conv_regs_cfg.svh ====
// Register offsets, field positions and reset values of the converter status and mask bank
`ifndef CONV_REGS_CFG_SVH
`define CONV_REGS_CFG_SVH

// =====================================================================
// Register offsets
`define TOP_FLAG_OFS       8'h1A
`define TOP_STATUS_OFS     8'h1E
`define PHASE01_STATUS_OFS 8'h1F
`define PHASE23_STATUS_OFS 8'h20
`define TOP_MASK_A_OFS     8'h21

// =====================================================================
// Field positions inside one status nibble
`define NIB_ENABLED_BIT    3
`define NIB_GOOD_BIT       2
`define NIB_LIMIT_BIT      0

// =====================================================================
// Field positions in the top status, flag and mask registers
`define SYNC_CLOCK_BIT     4
`define THERMAL_WARN_BIT   2
`define LOAD_READY_BIT     0
`define EVENT_BITS_MASK    8'h15

// =====================================================================
// Reset values
`define STATUS_RESET       8'h00
`define FLAG_RESET         8'h00
`define TOP_MASK_A_RESET   8'h80
`define READ_IDLE_VALUE    8'h00

`endif

// ==== rtl/conv_regs_pkg.sv ====
// State types of the converter status and mask bank
package conv_regs_pkg;

	// =====================================================================
	// Whole state of one phase-pair status register
	typedef struct packed {
		logic [7:0] status;
	} pair_state_t;

	// =====================================================================
	// Whole state of the register bank top
	typedef struct packed {
		logic [7:0] topMask;
		logic [7:0] flags;
		logic [7:0] topStat;
		logic [7:0] rdData;
		logic       irq;
	} bank_state_t;

endpackage

// ==== rtl/converter_status_mask_regs.sv ====
// Converter phase status, top status, event flags and interrupt mask registers
//
// Contract
// - Each phase reports enabled at bit 7 or 3 of its status register.
// - Each phase reports raw power-good at bit 6 or 2.
// - Each phase reports raw current limit at bit 4 or 0.
// - Phases 0,1 at 0x1F, phases 2,3 at 0x20; higher phase in upper nibble.
// - Mask bit 4 at 0x21 set blocks the external clock interrupt.
// - Mask bit 2 blocks thermal warning interrupt, never the raw thermal status.
// - Mask bit 0 set blocks the load-current-ready interrupt.
// - Status bits, reserved ones too, are read-only and read zero after reset.
// - External clock status reads 1 when its frequency is invalid.
`timescale 1ns/1ps
`include "conv_regs_cfg.svh"

module converter_status_mask_regs (
	input  wire logic       clk,                   // System clock, 100 MHz
	input  wire logic       rst,                   // Asynchronous reset, active high
	input  wire logic       ce,                    // Clock enable, freezes all state
	input  wire logic [7:0] regAddr,               // Register address
	input  wire logic       regWr,                 // Write strobe, one cycle
	input  wire logic [7:0] regWrData,             // Write data
	input  wire logic       regRd,                 // Read strobe, one cycle
	output logic      [7:0] regRdData,             // Read data, valid after regRd
	input  wire logic       phase0Enabled,         // Phase 0 is enabled
	input  wire logic       phase1Enabled,         // Phase 1 is enabled
	input  wire logic       phase2Enabled,         // Phase 2 is enabled
	input  wire logic       phase3Enabled,         // Phase 3 is enabled
	input  wire logic       phase0OutputGoodRaw,   // Phase 0 above power-good level
	input  wire logic       phase1OutputGoodRaw,   // Phase 1 above power-good level
	input  wire logic       phase2OutputGoodRaw,   // Phase 2 above power-good level
	input  wire logic       phase3OutputGoodRaw,   // Phase 3 above power-good level
	input  wire logic       phase0CurrentLimitRaw, // Phase 0 current limit active
	input  wire logic       phase1CurrentLimitRaw, // Phase 1 current limit active
	input  wire logic       phase2CurrentLimitRaw, // Phase 2 current limit active
	input  wire logic       phase3CurrentLimitRaw, // Phase 3 current limit active
	input  wire logic       syncClockInvalid,      // External sync clock not valid
	input  wire logic       thermalWarningRaw,     // Die above thermal warning level
	input  wire logic       loadReadyPulse,        // Load-current measurement done
	output logic            irq                    // Interrupt request, active high
);

	conv_regs_pkg::bank_state_t s_q;
	conv_regs_pkg::bank_state_t s_d;
	logic [7:0]                 phase01Stat;
	logic [7:0]                 phase23Stat;
	logic [7:0]                 rawTop;
	logic [7:0]                 events;
	logic [7:0]                 clearBits;

	// =====================================================================
	// Address match, used by every decode below
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		return addr == ofs;
	endfunction

	// =====================================================================
	// Phase status bytes
	// Kept in a sub-block so both pairs share one proven layout
	phase_pair_status pair01 (
		.clk          (clk),
		.rst          (rst),
		.ce           (ce),
		.enabled      ({phase1Enabled, phase0Enabled}),
		.outputGood   ({phase1OutputGoodRaw, phase0OutputGoodRaw}),
		.currentLimit ({phase1CurrentLimitRaw, phase0CurrentLimitRaw}),
		.statusByte   (phase01Stat)
	);

	phase_pair_status pair23 (
		.clk          (clk),
		.rst          (rst),
		.ce           (ce),
		.enabled      ({phase3Enabled, phase2Enabled}),
		.outputGood   ({phase3OutputGoodRaw, phase2OutputGoodRaw}),
		.currentLimit ({phase3CurrentLimitRaw, phase2CurrentLimitRaw}),
		.statusByte   (phase23Stat)
	);

	// =====================================================================
	// Raw top status and event detection
	// Raw bits are sampled unmasked; the mask only gates the interrupt
	always_comb begin
		rawTop = 8'h00;
		rawTop[`SYNC_CLOCK_BIT]   = syncClockInvalid;
		rawTop[`THERMAL_WARN_BIT] = thermalWarningRaw;
		events = 8'h00;
		// Rising edges of the level conditions, compared with last sample
		events[`SYNC_CLOCK_BIT]   = syncClockInvalid & ~s_q.topStat[`SYNC_CLOCK_BIT];
		events[`THERMAL_WARN_BIT] = thermalWarningRaw & ~s_q.topStat[`THERMAL_WARN_BIT];
		events[`LOAD_READY_BIT]   = loadReadyPulse;
		clearBits = 8'h00;
		if (regWr && hit(regAddr, `TOP_FLAG_OFS)) begin
			clearBits = regWrData & `EVENT_BITS_MASK;
		end
	end

	// =====================================================================
	// Next state of the bank
	always_comb begin
		s_d = s_q;
		s_d.topStat = rawTop;
		// Set wins over clear, so an event in the clearing cycle survives
		s_d.flags = (s_q.flags & ~clearBits) | events;
		// Status registers ignore writes; the mask stores write data, the flag register clears the bits written as one
		if (regWr && hit(regAddr, `TOP_MASK_A_OFS)) begin
			s_d.topMask = regWrData;
		end
		if (regRd) begin
			case (1'b1)
				hit(regAddr, `PHASE01_STATUS_OFS): begin
					s_d.rdData = phase01Stat;
				end
				hit(regAddr, `PHASE23_STATUS_OFS): begin
					s_d.rdData = phase23Stat;
				end
				hit(regAddr, `TOP_STATUS_OFS): begin
					s_d.rdData = s_q.topStat;
				end
				hit(regAddr, `TOP_MASK_A_OFS): begin
					s_d.rdData = s_q.topMask;
				end
				hit(regAddr, `TOP_FLAG_OFS): begin
					s_d.rdData = s_q.flags;
				end
				default: begin
					s_d.rdData = `READ_IDLE_VALUE;
				end
			endcase
		end
		// A mask bit at 1 blocks its flag; flags and mask share bit positions
		s_d.irq = |(s_q.flags & ~s_q.topMask & `EVENT_BITS_MASK);
	end

	// =====================================================================
	// State register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q <= '{topMask: `TOP_MASK_A_RESET, flags: `FLAG_RESET, topStat: `STATUS_RESET,
				rdData: `READ_IDLE_VALUE, irq: 1'b0};
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign regRdData = s_q.rdData;
	assign irq       = s_q.irq;

endmodule

// ==== rtl/phase_pair_status.sv ====
// Read-only status byte for two converter phases
`timescale 1ns/1ps
`include "conv_regs_cfg.svh"

module phase_pair_status (
	input  wire logic       clk,          // System clock
	input  wire logic       rst,          // Asynchronous reset, active high
	input  wire logic       ce,           // Clock enable, freezes state when low
	input  wire logic [1:0] enabled,      // Phase enabled, bit 0 lower phase
	input  wire logic [1:0] outputGood,   // Raw power-good, bit 0 lower phase
	input  wire logic [1:0] currentLimit, // Raw current limit, bit 0 lower phase
	output logic      [7:0] statusByte    // Registered status byte
);

	conv_regs_pkg::pair_state_t s_q;
	conv_regs_pkg::pair_state_t s_d;

	// =====================================================================
	// Nibble packing, shared by both phases so the layouts cannot drift
	function automatic logic [3:0] packNibble(input logic en, input logic pg, input logic lim);
		logic [3:0] n;
		n = 4'h0;
		n[`NIB_ENABLED_BIT] = en;
		n[`NIB_GOOD_BIT]    = pg;
		n[`NIB_LIMIT_BIT]   = lim;
		return n;
	endfunction

	// =====================================================================
	// Next state: higher phase high nibble, reserved bits stay zero
	always_comb begin
		s_d = s_q;
		s_d.status = {packNibble(enabled[1], outputGood[1], currentLimit[1]),
			packNibble(enabled[0], outputGood[0], currentLimit[0])};        // Lower phase
	end

	// Status is unlatched: it follows the inputs one clock late
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q <= '{status: `STATUS_RESET};
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign statusByte = s_q.status;

endmodule

// ==== tb/conv_regs_chk.sv ====
// Port checks for the converter status and mask registers
`timescale 1ns/1ps
module conv_regs_chk (
	input wire logic       clk,               // System clock
	input wire logic       rst,               // Asynchronous reset, active high
	input wire logic       ce,                // Clock enable
	input wire logic       regWr,             // Write strobe
	input wire logic       regRd,             // Read strobe
	input wire logic       irq,               // Interrupt request
	input wire logic [7:0] regAddr,           // Register address
	input wire logic [7:0] regWrData,         // Write data
	input wire logic [7:0] regRdData,         // Read data
	input wire logic       syncClockInvalid,  // External clock invalid
	input wire logic       thermalWarningRaw, // Die above warning level
	input wire logic       loadReadyPulse     // Load measurement done
);
	// ====
	// Mask shadow; up skips reads whose history reaches into reset
	logic [1:0] up;
	logic [7:0] mk;
	wire mw = ce && regWr && regAddr == 8'h21;
	wire rdOk = ce && regRd && up[1];
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			up <= 2'h0;
			mk <= 8'h80;
		end else begin
			up <= up[1] ? up : up + 2'h1;
			mk <= mw ? regWrData : mk;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ====
	// Assertions
	AST_TOP_STAT: assert property (rdOk && $past(ce) && regAddr == 8'h1E |=>
		regRdData == {3'h0, $past(syncClockInvalid, 2), 1'h0, $past(thermalWarningRaw, 2), 2'h0})
		else $error("Bad top status");
	AST_MASK_RW: assert property (mw ##1 (rdOk && regAddr == 8'h21 && !regWr) |=>
		regRdData == $past(regWrData, 2)) else $error("Bad mask");
	AST_UNMAPPED: assert property (rdOk && !(regAddr inside {8'h1A, [8'h1E:8'h21]}) |=>
		regRdData == 8'h00) else $error("Bad unmapped read");
	AST_RD_HOLD: assert property (!(ce && regRd) |=> $stable(regRdData))
		else $error("Read data moved");
	AST_LOAD_IRQ: assert property ((ce && loadReadyPulse && !mk[0] && !mw) ##1 ce |=> irq)
		else $error("No load irq");
	AST_THERM_IRQ: assert property ((ce && $past(ce) && up[1] && $rose(thermalWarningRaw)
		&& !mk[2] && !mw) ##1 ce |=> irq) else $error("No thermal irq");
	AST_SYNC_IRQ: assert property ((ce && $past(ce) && up[1] && $rose(syncClockInvalid)
		&& !mk[4] && !mw) ##1 ce |=> irq) else $error("No clock irq");
	AST_IRQ_QUIET: assert property (ce && (mk & 8'h15) == 8'h15 |=> !irq)
		else $error("Masked irq");
	cover property (mw ##1 rdOk);
	cover property ($rose(irq));
	cover property (rdOk && regAddr == 8'h1E);
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the converter status and mask registers
`timescale 1ns/1ps
module tb;
	logic clk, rst = 1'h1, ce = 1'h1, regWr = 1'h0, regRd = 1'h0, irq, rdDly = 1'h0;
	logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, b, expQ[$];
	logic [3:0] en = 4'h0, gd = 4'h0, lm = 4'h0; // Per-phase inputs
	logic [2:0] ev = 3'h0; // Load ready, thermal, sync clock
	int failCount = 0, comparisons = 0;
	converter_status_mask_regs converter_status_mask_regs_inst (
		.clk                   (clk),
		.rst                   (rst),
		.ce                    (ce),
		.regAddr               (regAddr),
		.regWr                 (regWr),
		.regWrData             (regWrData),
		.regRd                 (regRd),
		.regRdData             (regRdData),
		.phase0Enabled         (en[0]),
		.phase1Enabled         (en[1]),
		.phase2Enabled         (en[2]),
		.phase3Enabled         (en[3]),
		.phase0OutputGoodRaw   (gd[0]),
		.phase1OutputGoodRaw   (gd[1]),
		.phase2OutputGoodRaw   (gd[2]),
		.phase3OutputGoodRaw   (gd[3]),
		.phase0CurrentLimitRaw (lm[0]),
		.phase1CurrentLimitRaw (lm[1]),
		.phase2CurrentLimitRaw (lm[2]),
		.phase3CurrentLimitRaw (lm[3]),
		.syncClockInvalid      (ev[2]),
		.thermalWarningRaw     (ev[1]),
		.loadReadyPulse        (ev[0]),
		.irq                   (irq)
	);
	// Expected status byte of phase pair k, bit 1 of each nibble always zero
	function automatic logic [7:0] st(input int k);
		st = {en[2*k+1], gd[2*k+1], 1'h0, lm[2*k+1], en[2*k], gd[2*k], 1'h0, lm[2*k]};
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			failCount++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Bus tasks start after a rising edge; the idle edge after a read avoids double drives
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		regRd <= 1'h1;
		regAddr <= a;
		expQ.push_back(e);
		@(posedge clk) regRd <= 1'h0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		regWr <= 1'h1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk) regWr <= 1'h0;
	endtask
	task automatic testDone;
		if (expQ.size() != 0) failCount++;
		$display("checks %0d mismatches %0d", comparisons, failCount);
		if (failCount == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	// Read data is settled one edge after the read was taken
	always @(posedge clk) begin
		rdDly <= ce && regRd && !rst;
		if (rdDly && expQ.size() == 0) begin
			failCount++;
			$display("CHECK FAILED %0t read data without an expectation", $time);
		end
		if (rdDly && expQ.size() != 0) chk(regRdData, expQ.pop_front());
	end
	// Main sequence
	initial begin
		void'($urandom(32'hAFB6));
		repeat (4) @(posedge clk);
		rst <= 1'h0;
		rd(8'h1F, 8'h00);
		rd(8'h21, 8'h80);
		wr(8'h1F, 8'hFF);
		rd(8'h1F, 8'h00);
		wr(8'h20, 8'hFF);
		rd(8'h20, 8'h00);
		rd(8'h3C, 8'h00);
		for (int i = 0; i < 8; i++) begin
			{en, gd, lm} <= 12'($urandom);
			b = 8'($urandom);
			@(posedge clk);
			rd(8'h1F, st(0));
			rd(8'h20, st(1));
			wr(8'h21, b);
			rd(8'h21, b);
		end
		// Each event first masked, then allowed; the flag latches either way
		for (int i = 0; i < 3; i++) begin
			for (int p = 0; p < 2; p++) begin
				b = 8'h01 << (2 * i);
				wr(8'h21, p ? ~b : 8'hFF);
				ev[i] <= 1'h1;
				@(posedge clk) ev[0] <= 1'h0;
				rd(8'h1E, {3'h0, ev[2], 1'h0, ev[1], 2'h0});
				rd(8'h1A, b);
				@(negedge clk) chk({7'h00, irq}, {7'h00, p[0]});
				@(posedge clk) wr(8'h1A, b);
				repeat (3) @(negedge clk);
				chk({7'h00, irq}, 8'h00);
				@(posedge clk) ev[i] <= 1'h0;
			end
		end
		// Clock enable low: a load event and new phase inputs must leave no trace
		@(posedge clk);
		b = st(0);
		ce <= 1'h0;
		ev[0] <= 1'h1;
		{en, gd, lm} <= 12'hFFF;
		repeat (3) @(posedge clk);
		ce <= 1'h1;
		ev[0] <= 1'h0;
		rd(8'h1F, b);
		rd(8'h1A, 8'h00);
		rd(8'h1F, st(0));
		@(negedge clk) chk({7'h00, irq}, 8'h00);
		// Mid-run reset with every phase input high: the first status read is still zero
		@(posedge clk) rst <= 1'h1;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		rd(8'h1F, 8'h00);
		rd(8'h21, 8'h80);
		rd(8'h20, st(1));
		repeat (3) @(posedge clk);
		testDone();
	end
endmodule
bind converter_status_mask_regs conv_regs_chk conv_regs_chk_inst (
	.clk               (clk),
	.rst               (rst),
	.ce                (ce),
	.regWr             (regWr),
	.regRd             (regRd),
	.irq               (irq),
	.regAddr           (regAddr),
	.regWrData         (regWrData),
	.regRdData         (regRdData),
	.syncClockInvalid  (syncClockInvalid),
	.thermalWarningRaw (thermalWarningRaw),
	.loadReadyPulse    (loadReadyPulse)
);
